// ===== bench/eeprom_controller_monitor.sv
// eeprom_controller_monitor: bus answer and pin checks at the controller ports
`timescale 1ns/10ps
module eeprom_controller_monitor import eeprom_ctrl_pkg::*; #(
	parameter int unsigned STRETCH_CYC = 2000
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic [11:0] awaddr,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [1:0]  bresp,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [11:0] araddr,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        irq,
	input wire logic        scl_in,
	input wire logic        scl_oe,
	input wire logic        sda_oe
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic        bad_aw;
	int unsigned low_n;
	function automatic logic unmapped(logic [11:0] a);
		return !(a inside {OFF_HWCFG, OFF_CMD, OFF_DATA, OFF_IRQ_ST, OFF_IRQ_MASK});
	endfunction
	// remember whether the taken write address hits a register
	always_ff @(posedge aclk) begin
		if (awvalid && awready)
			bad_aw <= unmapped(awaddr);
	end
	// cycles the far side holds the clock low; saturates so it never wraps
	always_ff @(posedge aclk) begin
		if (!aresetn || scl_in || scl_oe)
			low_n <= 0;
		else if (low_n < STRETCH_CYC + 64)
			low_n <= low_n + 1;
	end
	sequence s_rd_taken;
		arvalid && arready;
	endsequence
	chk_idle_reset: assert property ($rose(aresetn) |-> !irq && !scl_oe && !sda_oe && !bvalid)
		else $error("outputs not idle after reset");
	chk_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	chk_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	chk_rd_answer: assert property (s_rd_taken |=> rvalid)
		else $error("read answer late");
	chk_bresp_code: assert property ($rose(bvalid) |-> bresp == (bad_aw ? RESP_SLVERR : RESP_OKAY))
		else $error("wrong write response");
	chk_rresp_code: assert property (s_rd_taken |=> rresp == (unmapped($past(araddr)) ? 2'h2 : 2'h0))
		else $error("wrong read response");
	chk_data_upper: assert property (s_rd_taken ##0 araddr == OFF_DATA |=> rdata[31:8] == 0)
		else $error("data upper bits set");
	chk_stretch_abort: assert property (low_n > STRETCH_CYC + 8 |-> !sda_oe)
		else $error("lines held after clock stretch limit");
endmodule

// ===== bench/i2c_eeprom_model.sv
// i2c_eeprom_model: byte memory answering on the two-wire bus
`timescale 1ns/10ps
module i2c_eeprom_model (
	input  wire logic       aclk,
	input  wire logic       scl,
	input  wire logic       sda,
	// 0 normal, 1 refuse every byte, 2 refuse address after a write
	input  wire logic [1:0] mode,
	output logic            sda_oe
);
	logic [7:0] mem [256];
	logic [7:0] sh, ptr;
	logic [3:0] bn;
	logic [1:0] idx;
	logic       rd, ack, ps, pd, wseen;
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = i[7:0] ^ 8'h3c;
		{sh, ptr, bn, idx, rd, ack, sda_oe, wseen} = '0;
		{ps, pd} = 2'b11;
	end
	// oversampled on the system clock; only the high byte of the pointer is dropped
	always @(posedge aclk) begin
		ps <= scl;
		pd <= sda;
		if (mode == 2'd0)
			wseen <= 1'b0;
		if (ps && scl && pd != sda) begin
			{bn, idx, rd, ack, sda_oe} <= {4'hf, 5'h00};
		end else if (!ps && scl && !rd && bn < 8) begin
			sh <= {sh[6:0], sda};
		end else if (ps && !scl) begin
			bn <= (bn == 8) ? 4'd0 : bn + 4'd1;
			if (bn == 7 && !rd) begin
				ack <= 1'b1;
				sda_oe <= !(mode == 2'd1 || (mode == 2'd2 && wseen && idx == 0));
				if (idx == 0)
					rd <= sh[0];
				if (idx == 2)
					ptr <= sh;
				if (idx == 3)
					{mem[ptr], ptr, wseen} <= {sh, ptr + 8'd1, 1'b1};
				if (idx != 3)
					idx <= idx + 2'd1;
			end else if (bn == 8 && rd && ack) begin
				{ack, sh, sda_oe} <= {1'b0, mem[ptr], !mem[ptr][7]};
			end else if (rd && bn < 7) begin
				{sh, sda_oe} <= {sh << 1, !sh[6]};
			end else begin
				{sda_oe, ack} <= 2'b00;
				if (rd && bn == 7)
					ptr <= ptr + 8'd1;
			end
		end
	end
endmodule

// ===== bench/test_serial_eeprom_command_controller.sv
// test_serial_eeprom_command_controller: register-level bench with eeprom model
`timescale 1ns/10ps
module test_serial_eeprom_command_controller;
	import eeprom_ctrl_pkg::*;
	localparam int unsigned WT = 2000, ST = 2000, AQ = 4000;
	logic        aclk, aresetn, digital_rst, host_mac_soft_reset, awvalid, wvalid, bready;
	logic        arvalid, rready, hold_scl, hold_sda, awready, wready, bvalid, arready;
	logic        rvalid, irq, scl_oe, sda_oe, m_oe;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_v;
	logic [15:0] ad;
	logic [7:0]  d, shadow [256];
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, mode, resp;
	int          n_fail, compares, cyc, t0, seed;
	wire         scl_in = !(scl_oe || hold_scl);
	wire         sda_in = !(sda_oe || m_oe || hold_sda);
	eeprom_controller #(.WR_TMO_CYC(WT), .STRETCH_CYC(ST), .ACQ_CYC(AQ), .QTR_DIV(4))
		i_eeprom_controller (.aclk, .aresetn, .digital_rst, .host_mac_soft_reset, .awvalid,
		.awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
		.arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .irq, .scl_in,
		.scl_out(), .scl_oe, .sda_in, .sda_out(), .sda_oe);
	i2c_eeprom_model i_i2c_eeprom_model (.aclk, .scl(scl_in), .sda(sda_in), .mode, .sda_oe(m_oe));
	initial begin
		aclk = 0;
		forever #12.5 aclk = !aclk;
	end
	// watchdog ceiling
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_fail++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", nm, e, g);
			n_fail++;
		end
	endtask
	function automatic logic [31:0] cmd_exp(logic t, logic l, logic [15:0] a, logic [2:0] c);
		return {1'b0, c, 10'h000, t, l, a};
	endfunction
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] dt);
		logic pa, pw, ka, kw;
		@(posedge aclk);
		{awvalid, wvalid, awaddr, wdata} <= {2'b11, a, dt};
		{pa, pw} = 2'b11;
		while (pa || pw) begin
			@(negedge aclk);
			{ka, kw} = {pa && awready, pw && wready};
			@(posedge aclk);
			{pa, pw} = {pa && !ka, pw && !kw};
			{awvalid, wvalid} <= {pa, pw};
		end
		bready <= 1;
		do @(negedge aclk); while (!bvalid);
		resp = bresp;
		@(posedge aclk);
		bready <= 0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		{arvalid, araddr} <= {1'b1, a};
		do @(negedge aclk); while (!arready);
		@(posedge aclk);
		{arvalid, rready} <= 2'b01;
		do @(negedge aclk); while (!rvalid);
		{rd_v, resp} = {rdata, rresp};
		@(posedge aclk);
		rready <= 0;
	endtask
	task automatic cmd(input logic [2:0] c, input logic [15:0] a);
		int t;
		t = cyc;
		wr(OFF_CMD, {1'b1, c, 12'h000, a});
		do rd(OFF_CMD); while (rd_v[CMD_BUSY_BIT] !== 1'b0);
		t0 = cyc - t;
	endtask
	initial begin
		seed = 32'h7c36_49b7;
		{aresetn, digital_rst, host_mac_soft_reset, awvalid, wvalid, bready} = '0;
		{arvalid, rready, hold_scl, hold_sda, mode, awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		for (int i = 0; i < 256; i++)
			shadow[i] = i[7:0] ^ 8'h3c;
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		rd(OFF_DATA);
		chk("data reset", 0, rd_v);
		rd(OFF_CMD);
		chk("cmd reset", 0, rd_v);
		rd(OFF_HWCFG);
		chk("ready reset", 1, rd_v[READY_BIT]);
		wr(12'h100, 32'h0000_0001);
		chk("unmapped wr", RESP_SLVERR, resp);
		rd(12'h100);
		chk("unmapped rd", RESP_SLVERR, resp);
		wr(OFF_DATA, 32'hffff_ffff);
		rd(OFF_DATA);
		chk("data field", 32'h0000_00ff, rd_v);
		repeat (3) begin
			ad = 16'($random(seed));
			cmd(CMD_READ, ad);
			rd(OFF_DATA);
			chk("read byte", {24'h0, shadow[ad[7:0]]}, rd_v);
		end
		// signature first so reloads succeed
		cmd(CMD_WEN, 0);
		for (int i = 0; i < 3; i++) begin
			ad = (i == 0) ? 16'h0000 : 16'($random(seed)) | 16'h0001;
			d = (i == 0) ? LOAD_SIG : 8'($random(seed));
			wr(OFF_DATA, {24'h0, d});
			cmd(CMD_WRITE, ad);
			cmd(CMD_READ, ad);
			rd(OFF_DATA);
			chk("write back", {24'h0, d}, rd_v);
		end
		mode <= 2;
		cmd(CMD_WRITE, 16'h0011);
		mode <= 0;
		chk("wr tmo", 1, rd_v[TMO_BIT]);
		chk("wr tmo late", 1, t0 >= WT);
		wr(OFF_CMD, 32'h0002_0000);
		rd(OFF_CMD);
		chk("tmo w1c", 0, rd_v[TMO_BIT]);
		wr(OFF_IRQ_MASK, 32'h0000_0001);
		cmd(CMD_WDIS, 0);
		@(negedge aclk);
		chk("irq on", 1, irq);
		wr(OFF_IRQ_MASK, 0);
		@(negedge aclk);
		chk("irq masked", 0, irq);
		wr(OFF_IRQ_MASK, 32'h0000_0001);
		wr(OFF_IRQ_ST, 32'h0000_0007);
		@(negedge aclk);
		chk("irq cleared", 0, irq);
		wr(OFF_DATA, 32'h0000_005a);
		cmd(CMD_WRITE, 0);
		cmd(CMD_READ, 0);
		rd(OFF_DATA);
		chk("wr disabled", {24'h0, LOAD_SIG}, rd_v);
		wr(OFF_CMD, {1'b1, CMD_RELOAD, 28'h0});
		rd(OFF_HWCFG);
		chk("ready in reload", 0, rd_v[READY_BIT]);
		do rd(OFF_CMD); while (rd_v[CMD_BUSY_BIT] !== 1'b0);
		chk("loaded", cmd_exp(0, 1, 0, CMD_RELOAD), rd_v);
		rd(OFF_HWCFG);
		chk("ready after", 1, rd_v[READY_BIT]);
		for (int i = 0; i < 3; i++) begin
			@(posedge aclk);
			{digital_rst, host_mac_soft_reset} <= (i == 0) ? 2'b10 : 2'b01;
			@(posedge aclk);
			{digital_rst, host_mac_soft_reset} <= 2'b00;
			if (i == 2)
				wr(OFF_CMD, 32'h0001_0000);
			rd(OFF_CMD);
			chk("loaded clr", 0, rd_v[LOADED_BIT]);
			cmd(CMD_RELOAD, 0);
		end
		mode <= 1;
		cmd(CMD_RELOAD, 0);
		mode <= 0;
		chk("bad reload", cmd_exp(1, 0, 0, CMD_RELOAD), rd_v);
		for (logic [2:0] c = 4; c < 7; c++) begin
			wr(OFF_CMD, 32'h0002_0000);
			cmd(c, 0);
			chk("bad code", cmd_exp(1, 0, 0, c), rd_v);
		end
		wr(OFF_CMD, 32'h0002_0000);
		fork
			cmd(CMD_READ, 16'h0022);
			begin
				repeat (300) @(posedge aclk);
				hold_scl <= 1;
				repeat (ST + 200) @(posedge aclk);
				hold_scl <= 0;
			end
		join
		chk("stretch tmo", 1, rd_v[TMO_BIT] && t0 >= ST);
		wr(OFF_CMD, 32'h0002_0000);
		hold_sda <= 1;
		cmd(CMD_READ, 16'h0033);
		hold_sda <= 0;
		chk("acquire tmo", 1, rd_v[TMO_BIT] && t0 >= AQ);
		print_verdict();
	end
endmodule
bind eeprom_controller eeprom_controller_monitor #(.STRETCH_CYC(STRETCH_CYC)) i_mon (.aclk,
	.aresetn, .awvalid, .awready, .awaddr, .bvalid, .bready, .bresp, .arvalid, .arready,
	.araddr, .rvalid, .rready, .rdata, .rresp, .irq, .scl_in, .scl_oe, .sda_oe);

// ===== hw/eeprom_controller.sv
// eeprom_controller: axi4-lite command/data registers driving a serial eeprom
`timescale 1ns/10ps
module eeprom_controller #(
	parameter int unsigned WR_TMO_CYC  = eeprom_ctrl_pkg::WR_TMO_CYC,
	parameter int unsigned STRETCH_CYC = eeprom_ctrl_pkg::STRETCH_CYC,
	parameter int unsigned ACQ_CYC     = eeprom_ctrl_pkg::ACQ_CYC,
	parameter int unsigned QTR_DIV     = eeprom_ctrl_pkg::QTR_DIV
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// soft resets, level, synchronous
	input  wire logic        digital_rst,
	input  wire logic        host_mac_soft_reset,
	// axi4-lite write address
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [11:0] awaddr,
	// axi4-lite write data
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	// axi4-lite write response
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	// axi4-lite read address
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [11:0] araddr,
	// axi4-lite read data
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	// interrupt
	output logic             irq,
	// eeprom bus, open drain
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe
);
	import eeprom_ctrl_pkg::*;

	// sequencer states, gray along the read path
	typedef enum logic [3:0] {
		C_IDLE   = 4'h0,
		C_START  = 4'h1,
		C_CTRL   = 4'h3,
		C_AHI    = 4'h2,
		C_ALO    = 4'h6,
		C_RSTART = 4'h7,
		C_RCTRL  = 4'h5,
		C_RDATA  = 4'h4,
		C_STOP   = 4'hc,
		C_WDATA  = 4'hd
	} seq_t;

	seq_t        seq_r;
	logic        issued_r, write_op_r, reload_r, poll_r, pend_poll_r, err_r, sig_ok_r;
	logic        wr_en_r, ready_r, ev_done_r, ev_tmo_r, ev_load_r, ev_rd_r;
	logic [2:0]  code_r, irq_st_r, irq_mask_r;
	logic [15:0] addr_r, eff_addr;
	logic [7:0]  data_r, eng_tx, eng_rx;
	logic        timeout_r, loaded_r, aw_hold_r, w_hold_r, busy, wr_fire, sel_cmd;
	logic [31:0] wtmo_r, wdata_r, wmask, rd_word;
	logic [11:0] awaddr_r, rd_addr;
	logic [3:0]  wstrb_r;
	logic        start_cmd, reload_start, wtmo_hit, qtick, eng_valid, eng_ready;
	i2c_op_t     eng_op;
	logic        eng_done, eng_fail, eng_acked, rd_ok;

	if (WR_TMO_CYC < 1 || QTR_DIV < 2) begin : g_bad_par
		$error("eeprom_controller: timing parameters out of range");
	end

	// byte strobes to a bit mask
	function automatic logic [31:0] strb_mask(input logic [3:0] s);
		strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	// write channel: address and data taken in either order, one at a time
	assign awready  = !aw_hold_r;
	assign wready   = !w_hold_r;
	assign wr_fire  = aw_hold_r && w_hold_r && !bvalid;
	assign wmask    = strb_mask(wstrb_r);
	assign sel_cmd  = wr_fire && awaddr_r == OFF_CMD;
	assign busy     = seq_r != C_IDLE || ev_done_r;
	// a command write while busy starts nothing and leaves the fields; its w1c flag clears still apply
	assign start_cmd    = sel_cmd && !busy && wmask[CMD_BUSY_BIT] && wdata_r[CMD_BUSY_BIT];
	assign reload_start = start_cmd && wdata_r[CMD_CODE_LSB +: 3] == CMD_RELOAD;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			awaddr_r  <= 12'h000;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r  <= {awaddr[ADDR_W-1:2], 2'b00};
			end
			if (wvalid && wready) begin
				w_hold_r <= 1'b1;
				wdata_r  <= wdata;
				wstrb_r  <= wstrb;
			end
			if (wr_fire) begin
				aw_hold_r <= 1'b0;
				w_hold_r  <= 1'b0;
				bvalid    <= 1'b1;
				bresp     <= (awaddr_r == OFF_CMD || awaddr_r == OFF_DATA ||
					awaddr_r == OFF_HWCFG || awaddr_r == OFF_IRQ_ST ||
					awaddr_r == OFF_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// address, code and data fields; software writes ignored while busy
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_r <= ADDR_RST;
			code_r <= CMD_READ;
			data_r <= DATA_RST;
		end else begin
			if (sel_cmd && !busy) begin
				addr_r <= (addr_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
				if (wmask[CMD_CODE_LSB])
					code_r <= wdata_r[CMD_CODE_LSB +: 3];
			end
			if (ev_rd_r)
				data_r <= eng_rx;
			else if (wr_fire && awaddr_r == OFF_DATA && !busy)
				data_r <= (data_r & ~wmask[7:0]) | (wdata_r[7:0] & wmask[7:0]);
		end
	end

	// sticky flags: a set in the clearing cycle wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timeout_r  <= 1'b0;
			loaded_r   <= 1'b0;
			irq_st_r   <= 3'h0;
			irq_mask_r <= 3'h0;
		end else begin
			timeout_r <= ev_tmo_r | (timeout_r &
				~(sel_cmd && wmask[TMO_BIT] && wdata_r[TMO_BIT]));
			loaded_r <= ev_load_r | (loaded_r &
				~(sel_cmd && wmask[LOADED_BIT] && wdata_r[LOADED_BIT]) &
				~digital_rst & ~host_mac_soft_reset & ~reload_start);
			irq_st_r <= {ev_load_r, ev_tmo_r, ev_done_r} | (irq_st_r &
				~((wr_fire && awaddr_r == OFF_IRQ_ST) ? wdata_r[2:0] & wmask[2:0] : 3'h0));
			if (wr_fire && awaddr_r == OFF_IRQ_MASK && wmask[0])
				irq_mask_r <= wdata_r[2:0];
		end
	end

	assign irq = |(irq_st_r & irq_mask_r);

	// write-cycle timer runs only while acknowledge polling
	assign wtmo_hit = wtmo_r >= WR_TMO_CYC;

	always_ff @(posedge aclk) begin
		if (!aresetn || !poll_r)
			wtmo_r <= 32'h0000_0000;
		else if (!wtmo_hit)
			wtmo_r <= wtmo_r + 32'h0000_0001;
	end

	// engine request for the current sequencer state
	assign eff_addr  = reload_r ? LOAD_ADDR : addr_r;
	assign eng_valid = seq_r != C_IDLE && !issued_r;
	assign eng_op    = (seq_r == C_START || seq_r == C_RSTART) ? OP_START :
		(seq_r == C_STOP) ? OP_STOP : (seq_r == C_RDATA) ? OP_READ : OP_WRITE;
	assign eng_tx    = (seq_r == C_CTRL)  ? {DEV_ADDR, 1'b0} :
		(seq_r == C_RCTRL) ? {DEV_ADDR, 1'b1} :
		(seq_r == C_AHI)   ? eff_addr[15:8] :
		(seq_r == C_ALO)   ? eff_addr[7:0] : data_r;

	// command sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seq_r       <= C_IDLE;
			issued_r    <= 1'b0;
			write_op_r  <= 1'b0;
			reload_r    <= 1'b0;
			poll_r      <= 1'b0;
			pend_poll_r <= 1'b0;
			err_r       <= 1'b0;
			sig_ok_r    <= 1'b0;
			wr_en_r     <= 1'b0;
			ready_r     <= 1'b1;
			ev_done_r   <= 1'b0;
			ev_tmo_r    <= 1'b0;
			ev_load_r   <= 1'b0;
			ev_rd_r     <= 1'b0;
		end else begin
			ev_done_r <= 1'b0;
			ev_tmo_r  <= 1'b0;
			ev_load_r <= 1'b0;
			ev_rd_r   <= 1'b0;
			if (eng_valid && eng_ready)
				issued_r <= 1'b1;
			if (start_cmd) begin
				err_r       <= 1'b0;
				poll_r      <= 1'b0;
				pend_poll_r <= 1'b0;
				sig_ok_r    <= 1'b0;
				write_op_r  <= wdata_r[CMD_CODE_LSB +: 3] == CMD_WRITE;
				reload_r    <= wdata_r[CMD_CODE_LSB +: 3] == CMD_RELOAD;
				case (wdata_r[CMD_CODE_LSB +: 3])
					CMD_READ: seq_r <= C_START;
					CMD_WRITE: begin
						// write while disabled completes with no bus traffic
						if (wr_en_r)
							seq_r <= C_START;
						else
							ev_done_r <= 1'b1;
					end
					CMD_WEN: begin
						wr_en_r   <= 1'b1;
						ev_done_r <= 1'b1;
					end
					CMD_WDIS: begin
						wr_en_r   <= 1'b0;
						ev_done_r <= 1'b1;
					end
					CMD_RELOAD: begin
						seq_r   <= C_START;
						ready_r <= 1'b0;
					end
					default: begin
						ev_tmo_r  <= 1'b1;
						ev_done_r <= 1'b1;
					end
				endcase
			end else if (eng_done) begin
				issued_r <= 1'b0;
				if (seq_r == C_STOP || eng_fail) begin
					if (pend_poll_r && !err_r && !eng_fail) begin
						seq_r  <= C_START;
						poll_r <= 1'b1;
					end else begin
						seq_r       <= C_IDLE;
						poll_r      <= 1'b0;
						pend_poll_r <= 1'b0;
						ready_r     <= 1'b1;
						ev_done_r   <= 1'b1;
						ev_tmo_r    <= err_r | eng_fail;
						ev_load_r   <= reload_r && sig_ok_r && !err_r && !eng_fail;
						ev_rd_r     <= !reload_r && !write_op_r && !err_r && !eng_fail;
					end
				end else if (eng_op == OP_WRITE && !eng_acked &&
					!(poll_r && seq_r == C_CTRL)) begin
					// a missing ack releases the bus with a stop before reporting
					err_r <= 1'b1;
					seq_r <= C_STOP;
				end else begin
					case (seq_r)
						C_START: seq_r <= C_CTRL;
						C_CTRL: begin
							if (poll_r) begin
								seq_r <= C_STOP;
								if (eng_acked)
									pend_poll_r <= 1'b0;
								else if (wtmo_hit)
									err_r <= 1'b1;
							end else begin
								seq_r <= C_AHI;
							end
						end
						C_AHI: seq_r <= C_ALO;
						C_ALO: seq_r <= write_op_r ? C_WDATA : C_RSTART;
						C_WDATA: begin
							seq_r       <= C_STOP;
							pend_poll_r <= 1'b1;
						end
						C_RSTART: seq_r <= C_RCTRL;
						C_RCTRL: seq_r <= C_RDATA;
						C_RDATA: begin
							seq_r    <= C_STOP;
							sig_ok_r <= eng_rx == LOAD_SIG;
						end
						default: seq_r <= C_STOP;
					endcase
				end
			end
		end
	end

	// read mux; reserved bits read zero
	assign rd_addr = {araddr[ADDR_W-1:2], 2'b00};

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok   = 1'b1;
		case (rd_addr)
			OFF_CMD: begin
				rd_word[CMD_BUSY_BIT]          = busy;
				rd_word[CMD_CODE_LSB +: 3]     = code_r;
				rd_word[TMO_BIT]               = timeout_r;
				rd_word[LOADED_BIT]            = loaded_r;
				rd_word[15:0]                  = addr_r;
			end
			OFF_DATA:     rd_word[7:0] = data_r;
			OFF_HWCFG:    rd_word[READY_BIT] = ready_r;
			OFF_IRQ_ST:   rd_word[2:0] = irq_st_r;
			OFF_IRQ_MASK: rd_word[2:0] = irq_mask_r;
			default:      rd_ok = 1'b0;
		endcase
	end

	// read channel: one outstanding read
	assign arready = !rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= rd_word;
			rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	tick_divider #(
		.DIV (QTR_DIV)
	) u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (qtick)
	);

	i2c_byte_engine #(
		.STRETCH_CYC (STRETCH_CYC),
		.ACQ_CYC     (ACQ_CYC)
	) u_eng (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.qtick    (qtick),
		.op_valid (eng_valid),
		.op_ready (eng_ready),
		.op       (eng_op),
		.tx_byte  (eng_tx),
		.rx_nack  (1'b1),
		.op_done  (eng_done),
		.op_fail  (eng_fail),
		.acked    (eng_acked),
		.rx_byte  (eng_rx),
		.scl_in   (scl_in),
		.scl_out  (scl_out),
		.scl_oe   (scl_oe),
		.sda_in   (sda_in),
		.sda_out  (sda_out),
		.sda_oe   (sda_oe)
	);
endmodule

// ===== hw/eeprom_ctrl_pkg.sv
// package: eeprom controller register map, field layout, codes and timing
// Notes on behaviour
// - read command loads addressed byte into data
// - enabled write stores data byte at address
// - reload reruns loader, ready drops meanwhile
// - write unanswered for 30 ms sets timeout
// - missing ack or bad code sets timeout
// - clock held low over 30 ms sets timeout
// - bus not won in 1.92 s sets timeout
// - timeout bit 17, resets zero, write-one clears
// - loaded bit 16 set on good load, w1c
// - loaded clears on resets and reload start
// - data byte in 7:0, upper bits read zero
package eeprom_ctrl_pkg;
	// clock and derived timing
	localparam int unsigned CLK_HZ      = 40_000_000;
	localparam int unsigned I2C_HZ      = 100_000;
	localparam int unsigned WR_TMO_MS   = 30;
	localparam int unsigned STRETCH_MS  = 30;
	localparam int unsigned ACQ_MS      = 1920;
	localparam int unsigned WR_TMO_CYC  = WR_TMO_MS * (CLK_HZ / 1000);
	localparam int unsigned STRETCH_CYC = STRETCH_MS * (CLK_HZ / 1000);
	localparam int unsigned ACQ_CYC     = ACQ_MS * (CLK_HZ / 1000);
	localparam int unsigned QTR_DIV     = CLK_HZ / (4 * I2C_HZ);
	// register map, byte addresses
	localparam int unsigned ADDR_W       = 12;
	localparam logic [11:0] OFF_HWCFG    = 12'h074;
	localparam logic [11:0] OFF_CMD      = 12'h1b4;
	localparam logic [11:0] OFF_DATA     = 12'h1b8;
	localparam logic [11:0] OFF_IRQ_ST   = 12'h1c0;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h1c4;
	// field positions and reset values
	localparam int unsigned CMD_BUSY_BIT = 31;
	localparam int unsigned CMD_CODE_LSB = 28;
	localparam int unsigned TMO_BIT      = 17;
	localparam int unsigned LOADED_BIT   = 16;
	localparam int unsigned READY_BIT    = 0;
	localparam int unsigned IRQ_DONE     = 0;
	localparam int unsigned IRQ_TMO      = 1;
	localparam int unsigned IRQ_LOADED   = 2;
	localparam logic [15:0] ADDR_RST     = 16'h0000;
	localparam logic [7:0]  DATA_RST     = 8'h00;
	// command codes
	localparam logic [2:0] CMD_READ   = 3'h0;
	localparam logic [2:0] CMD_WDIS   = 3'h1;
	localparam logic [2:0] CMD_WEN    = 3'h2;
	localparam logic [2:0] CMD_WRITE  = 3'h3;
	localparam logic [2:0] CMD_RELOAD = 3'h7;
	// eeprom bus addressing and loader
	localparam logic [6:0]  DEV_ADDR  = 7'h50;
	localparam logic [15:0] LOAD_ADDR = 16'h0000;
	localparam logic [7:0]  LOAD_SIG  = 8'ha5;
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// byte engine operations
	typedef enum logic [1:0] {
		OP_START = 2'h0,
		OP_WRITE = 2'h1,
		OP_READ  = 2'h3,
		OP_STOP  = 2'h2
	} i2c_op_t;
endpackage

// ===== hw/i2c_byte_engine.sv
// i2c_byte_engine: start, stop, byte write and byte read on open-drain lines
`timescale 1ns/10ps
module i2c_byte_engine #(
	parameter int unsigned STRETCH_CYC = eeprom_ctrl_pkg::STRETCH_CYC,
	parameter int unsigned ACQ_CYC     = eeprom_ctrl_pkg::ACQ_CYC
) (
	// clock, reset and quarter-bit enable
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire logic                     qtick,
	// operation request
	input  wire logic                     op_valid,
	output logic                          op_ready,
	input  wire eeprom_ctrl_pkg::i2c_op_t op,
	input  wire logic [7:0]               tx_byte,
	input  wire logic                     rx_nack,
	// operation result
	output logic                          op_done,
	output logic                          op_fail,
	output logic                          acked,
	output logic [7:0]                    rx_byte,
	// open-drain bus lines
	input  wire logic                     scl_in,
	output logic                          scl_out,
	output logic                          scl_oe,
	input  wire logic                     sda_in,
	output logic                          sda_out,
	output logic                          sda_oe
);
	import eeprom_ctrl_pkg::*;

	typedef enum logic [1:0] {
		E_IDLE  = 2'h0,
		E_START = 2'h1,
		E_BITS  = 2'h3,
		E_STOP  = 2'h2
	} eng_t;

	eng_t        st_r;
	logic [1:0]  ph_r;
	logic [3:0]  bit_r;
	logic [8:0]  sh_r;
	logic        scl_rel_r, sda_rel_r, blocked, wait_hit;
	logic [31:0] wait_r;

	if (STRETCH_CYC < 1 || ACQ_CYC < 1) begin : g_bad_tmo
		$error("i2c_byte_engine: timeouts must be non-zero");
	end

	// lines are only ever pulled low; released means oe off
	assign op_ready = st_r == E_IDLE;
	assign scl_out  = 1'b0;
	assign sda_out  = 1'b0;
	assign scl_oe   = ~scl_rel_r;
	assign sda_oe   = ~sda_rel_r;

	// phase 2 waits for scl high (stretch) and, before a start, for a free bus
	assign blocked  = st_r != E_IDLE && ph_r == 2'h2 &&
		!(scl_in && (st_r != E_START || sda_in));
	assign wait_hit = wait_r >= ((st_r == E_START) ? ACQ_CYC : STRETCH_CYC);

	// phase sequencer: 0 set data, 1 release clock, 2 sample, 3 pull clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r      <= E_IDLE;
			ph_r      <= 2'h0;
			bit_r     <= 4'h0;
			sh_r      <= 9'h000;
			scl_rel_r <= 1'b1;
			sda_rel_r <= 1'b1;
			wait_r    <= 32'h0000_0000;
			op_done   <= 1'b0;
			op_fail   <= 1'b0;
			acked     <= 1'b0;
			rx_byte   <= 8'h00;
		end else begin
			op_done <= 1'b0;
			op_fail <= 1'b0;
			if (st_r == E_IDLE) begin
				if (op_valid) begin
					st_r  <= (op == OP_START) ? E_START : (op == OP_STOP) ? E_STOP : E_BITS;
					ph_r  <= 2'h0;
					bit_r <= 4'h0;
					sh_r  <= (op == OP_READ) ? {8'hff, rx_nack} : {tx_byte, 1'b1};
				end
			end else if (blocked) begin
				wait_r <= wait_r + 32'h0000_0001;
				// give up and let go of both lines
				if (wait_hit) begin
					st_r      <= E_IDLE;
					op_done   <= 1'b1;
					op_fail   <= 1'b1;
					scl_rel_r <= 1'b1;
					sda_rel_r <= 1'b1;
					wait_r    <= 32'h0000_0000;
				end
			end else if (qtick) begin
				wait_r <= 32'h0000_0000;
				ph_r   <= ph_r + 2'h1;
				unique case (ph_r)
					2'h0: sda_rel_r <= (st_r == E_BITS) ? sh_r[8] : (st_r == E_START);
					2'h1: scl_rel_r <= 1'b1;
					2'h2: begin
						if (st_r == E_BITS)
							sh_r <= {sh_r[7:0], sda_in};
						else
							sda_rel_r <= st_r == E_STOP;
					end
					2'h3: begin
						if (st_r != E_STOP)
							scl_rel_r <= 1'b0;
						bit_r <= bit_r + 4'h1;
						if (st_r != E_BITS || bit_r == 4'h8) begin
							st_r    <= E_IDLE;
							op_done <= 1'b1;
						end
						if (st_r == E_BITS && bit_r == 4'h8) begin
							rx_byte <= sh_r[8:1];
							acked   <= ~sh_r[0];
						end
					end
				endcase
			end
		end
	end
endmodule

// ===== hw/tick_divider.sv
// tick_divider: one-cycle enable pulse every DIV clocks
`timescale 1ns/10ps
module tick_divider #(
	parameter int unsigned DIV = eeprom_ctrl_pkg::QTR_DIV
) (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// enable pulse
	output logic      tick
);
	import eeprom_ctrl_pkg::*;

	logic [15:0] cnt_r;

	if (DIV < 2 || DIV > 65536) begin : g_bad_div
		$error("tick_divider: DIV out of range");
	end

	// free-running count, pulse on wrap
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= 16'h0000;
			tick  <= 1'b0;
		end else begin
			tick  <= cnt_r == 16'(DIV - 1);
			cnt_r <= (cnt_r == 16'(DIV - 1)) ? 16'h0000 : cnt_r + 16'h0001;
		end
	end
endmodule
